// *** cache_ctrl_pkg.sv ***
// Overview of operation
// RQ1 - Non-secure enable write: decode error, no change
// RQ2 - Enable register readable by any access
// RQ3 - Enable change: lock, drain, update, respond
// RQ4 - Enable bit 0 resets 0, upper bits zero
// RQ5 - Non-secure aux write: decode error, no change
// RQ6 - Aux write while enabled: slave error
// RQ7 - Decode error outranks slave error
// RQ8 - Writers use secure access, preserve reserved bits
// RQ9 - Early response and zero-line bits reset 0
// RQ10 - Prefetch enable bits reset 0
// RQ11 - Bit 27 opens interrupt registers to non-secure
// RQ12 - Bit 26 opens lockdown writes to non-secure
// RQ13 - Bit 25 picks round-robin, resets 1
// RQ14 - Write allocate field, 11 acts as 00
// RQ15 - Bit 22 ignores shared attribute
// RQ16 - Parity and event bus enables reset 0
// RQ17 - Way size coding clamped, reset from strap
// RQ18 - Bit 16 selects 8 or 16 ways
// RQ19 - Shared invalidate only without override
// RQ20 - Bit 12 enables exclusive configuration
// RQ21 - Bit 11 keeps a store slot free
// RQ22 - Bit 10 gives device reads top priority
// RQ23 - Associativity resets from strap input
// RQ24 - Stall register accesses during enable drain
package cache_ctrl_pkg;

  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] AUX_OFFSET  = 8'h04;

  localparam int ENABLE_BIT        = 0;
  localparam int AUX_ZERO_LINE     = 0;
  localparam int AUX_DEV_PRIO      = 10;
  localparam int AUX_SB_LIMIT      = 11;
  localparam int AUX_EXCLUSIVE     = 12;
  localparam int AUX_SHARED_INV    = 13;
  localparam int AUX_ASSOC         = 16;
  localparam int AUX_WAY_SIZE_STRAP_LO    = 17;
  localparam int AUX_WAY_SIZE_STRAP_HI    = 19;
  localparam int AUX_EVENT_BUS     = 20;
  localparam int AUX_PARITY        = 21;
  localparam int AUX_SHARED_OVR    = 22;
  localparam int AUX_WA_LO         = 23;
  localparam int AUX_WA_HI         = 24;
  localparam int AUX_ROUND_ROBIN   = 25;
  localparam int AUX_NS_LOCKDOWN   = 26;
  localparam int AUX_NS_INTERRUPT  = 27;
  localparam int AUX_DATA_PREFETCH = 28;
  localparam int AUX_INST_PREFETCH = 29;
  localparam int AUX_EARLY_RESP    = 30;

  // Writable aux bits; 31, 15:14 and 9:1 read as zero
  localparam logic [31:0] AUX_WRITE_MASK = 32'h7fff_3c01;
  // Fixed reset part; way size and associativity come from straps
  localparam logic [31:0] AUX_RESET_VAL  = 32'h0200_0000;
  localparam logic        CTRL_RESET_VAL = 1'b0;

  localparam logic [1:0] WA_ATTR   = 2'b00;
  localparam logic [1:0] WA_NEVER  = 2'b01;
  localparam logic [1:0] WA_ALWAYS = 2'b10;

  localparam logic [2:0] WAY_16KB  = 3'b001;
  localparam logic [2:0] WAY_512KB = 3'b110;

  localparam logic [1:0] RESP_OK     = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DRAIN = 3'b010,
    ST_RESP  = 3'b100
  } drain_state_t;

endpackage

// *** cache_ctrl_regs.sv ***
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module cache_ctrl_regs
  import cache_ctrl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        nonsecure_access_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  output logic      [1:0]  resp_o,
  input  wire logic [2:0]  way_size_strap_i,
  input  wire logic        assoc_strap_i,
  output logic             port_lock_o,
  output logic             sync_req_o,
  input  wire logic        sync_done_i,
  output logic             cache_enable_o,
  output logic             early_resp_en_o,
  output logic             inst_prefetch_en_o,
  output logic             data_prefetch_en_o,
  output logic             ns_int_access_o,
  output logic             ns_lockdown_en_o,
  output logic             round_robin_o,
  output logic      [1:0]  write_allocate_attr_o,
  output logic             shared_ovr_o,
  output logic             parity_en_o,
  output logic             event_bus_en_o,
  output logic      [2:0]  way_size_o,
  output logic             assoc16_o,
  output logic             shared_inv_o,
  output logic             exclusive_en_o,
  output logic             sb_dev_limit_o,
  output logic             dev_read_prio_o,
  output logic             zero_line_en_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic [2:0] clamp_way(input logic [2:0] w);
    if (w < WAY_16KB) begin
      clamp_way = WAY_16KB;
    end else if (w > WAY_512KB) begin
      clamp_way = WAY_512KB;
    end else begin
      clamp_way = w;
    end
  endfunction

  drain_state_t state_q, state_d;
  logic         enable_q, enable_d;
  logic [31:0]  aux_q, aux_d;
  logic [31:0]  dat_q, dat_d;
  logic         ack_q, ack_d;
  logic [1:0]   resp_q, resp_d;
  logic         strap_load_q;

  wire req        = cyc_i && stb_i && !ack_q;
  wire hit_ctrl   = adr_i == CTRL_OFFSET;
  wire hit_aux    = adr_i == AUX_OFFSET;
  wire hit_any    = hit_ctrl || hit_aux;
  wire full_word  = sel_i == 4'hf;
  wire idle       = state_q == ST_IDLE;
  wire wr_ctrl    = req && idle && we_i && hit_ctrl;
  wire wr_aux     = req && idle && we_i && hit_aux;
  // Decode error first, slave error only for secure writes RQ7
  wire ns_reject  = nonsecure_access_i;
  wire aux_busy   = enable_q;
  // Secure full-word enable writes always run the drain, even with unchanged value
  wire ctrl_start = wr_ctrl && !ns_reject && full_word;
  wire aux_ok     = wr_aux && !ns_reject && !aux_busy && full_word;
  wire [31:0] rd_val = hit_ctrl ? {31'h0, enable_q} : // RQ2 RQ4
                       hit_aux  ? aux_q : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Access and drain sequencing

  always_comb begin
    state_d  = state_q;
    enable_d = enable_q;
    aux_d    = aux_q;
    dat_d    = dat_q;
    ack_d    = 1'b0;
    resp_d   = resp_q;
    unique case (state_q)
      ST_IDLE: begin
        if (ctrl_start) begin
          state_d = ST_DRAIN; // RQ3
        end else if (req) begin
          ack_d  = 1'b1;
          resp_d = RESP_OK;
          dat_d  = 32'h0;
          if (!we_i) begin
            dat_d = rd_val; // RQ2
          end else if (!hit_any) begin
            resp_d = RESP_DECERR;
          end else if (ns_reject) begin
            resp_d = RESP_DECERR; // RQ1 RQ5 RQ7
          end else if (hit_aux && aux_busy) begin
            resp_d = RESP_SLVERR; // RQ6
          end else if (!full_word) begin
            resp_d = RESP_SLVERR;
          end
          if (aux_ok) begin
            aux_d = dat_i & AUX_WRITE_MASK; // RQ8
          end
        end
      end
      ST_DRAIN: begin
        // Bus stays stalled here, so no other access can slip in RQ24
        if (sync_done_i) begin
          enable_d = dat_i[ENABLE_BIT]; // RQ3
          state_d  = ST_RESP;
        end
      end
      ST_RESP: begin
        ack_d   = 1'b1; // RQ3
        resp_d  = RESP_OK;
        dat_d   = 32'h0;
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q  <= ST_IDLE;
      enable_q <= CTRL_RESET_VAL; // RQ4
      dat_q    <= 32'h0;
      ack_q    <= 1'b0;
      resp_q   <= RESP_OK;
    end else begin
      state_q  <= state_d;
      enable_q <= enable_d;
      dat_q    <= dat_d;
      ack_q    <= ack_d;
      resp_q   <= resp_d;
    end
  end

  // Straps are sampled on the first clock after reset release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_load_q <= 1'b1;
      aux_q        <= AUX_RESET_VAL; // RQ9 RQ10 RQ13 RQ16
    end else begin
      strap_load_q <= 1'b0;
      if (strap_load_q) begin
        aux_q <= AUX_RESET_VAL
               | {12'h0, way_size_strap_i, 17'h0} // RQ17
               | {15'h0, assoc_strap_i, 16'h0}; // RQ23
      end else begin
        aux_q <= aux_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign dat_o  = dat_q;
  assign ack_o  = ack_q;
  assign resp_o = resp_q;
  assign err_o  = ack_q && (resp_q != RESP_OK);

  // Slave ports locked and sync requested for the whole drain RQ3
  assign port_lock_o = state_q != ST_IDLE;
  assign sync_req_o  = state_q == ST_DRAIN;

  assign cache_enable_o     = enable_q;
  assign early_resp_en_o    = aux_q[AUX_EARLY_RESP]; // RQ9
  assign zero_line_en_o     = aux_q[AUX_ZERO_LINE]; // RQ9
  assign inst_prefetch_en_o = aux_q[AUX_INST_PREFETCH]; // RQ10
  assign data_prefetch_en_o = aux_q[AUX_DATA_PREFETCH]; // RQ10
  assign ns_int_access_o    = aux_q[AUX_NS_INTERRUPT]; // RQ11
  assign ns_lockdown_en_o   = aux_q[AUX_NS_LOCKDOWN]; // RQ12
  assign round_robin_o      = aux_q[AUX_ROUND_ROBIN]; // RQ13
  // Reserved code folds onto attribute-driven allocation
  assign write_allocate_attr_o =
    (aux_q[AUX_WA_HI:AUX_WA_LO] == WA_NEVER)  ? WA_NEVER  :
    (aux_q[AUX_WA_HI:AUX_WA_LO] == WA_ALWAYS) ? WA_ALWAYS : WA_ATTR; // RQ14
  assign shared_ovr_o   = aux_q[AUX_SHARED_OVR]; // RQ15
  assign parity_en_o    = aux_q[AUX_PARITY]; // RQ16
  assign event_bus_en_o = aux_q[AUX_EVENT_BUS]; // RQ16
  assign way_size_o     =
    clamp_way(aux_q[AUX_WAY_SIZE_STRAP_HI:AUX_WAY_SIZE_STRAP_LO]); // RQ17
  assign assoc16_o      = aux_q[AUX_ASSOC]; // RQ18
  assign shared_inv_o   = aux_q[AUX_SHARED_INV]
                          && !aux_q[AUX_SHARED_OVR]; // RQ19
  assign exclusive_en_o  = aux_q[AUX_EXCLUSIVE]; // RQ20
  assign sb_dev_limit_o  = aux_q[AUX_SB_LIMIT]; // RQ21
  assign dev_read_prio_o = aux_q[AUX_DEV_PRIO]; // RQ22

endmodule

// *** cache_ctrl_chk.sv ***
`timescale 1ns/1ps
module cache_ctrl_chk
  import cache_ctrl_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic        nonsecure_access_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [1:0]  resp_o,
  input wire logic        port_lock_o,
  input wire logic        sync_req_o,
  input wire logic        cache_enable_o,
  input wire logic [1:0]  write_allocate_attr_o,
  input wire logic [2:0]  way_size_o,
  input wire logic        round_robin_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take = cyc_i && stb_i && !ack_o && !port_lock_o;
  wire regw = take && we_i && (adr_i == CTRL_OFFSET || adr_i == AUX_OFFSET);
  wire enw = take && we_i && !nonsecure_access_i && adr_i == CTRL_OFFSET
             && sel_i == 4'hf;
  sequence drain_s;
    port_lock_o && sync_req_o && !ack_o;
  endsequence
  sequence answer_s(logic [1:0] c);
    ack_o && resp_o == c;
  endsequence
  chk_ns_write_dec: assert property (regw && nonsecure_access_i
    |=> answer_s(RESP_DECERR)) else $error("ns write not refused");
  chk_aux_busy_err: assert property (regw && !nonsecure_access_i
    && adr_i == AUX_OFFSET && cache_enable_o |=> answer_s(RESP_SLVERR))
    else $error("aux write while enabled accepted");
  chk_read_ok: assert property (take && !we_i |=> answer_s(RESP_OK))
    else $error("read refused");
  chk_ctrl_read_data: assert property (take && !we_i
    && adr_i == CTRL_OFFSET |=> dat_o == {31'h0, cache_enable_o})
    else $error("ctrl read data wrong");
  chk_drain_starts: assert property (enw |=> drain_s)
    else $error("enable write did not lock and drain");
  chk_update_after_drain: assert property ($changed(cache_enable_o)
    |-> $fell(sync_req_o)) else $error("enable changed outside drain");
  chk_resp_after_update: assert property ($changed(cache_enable_o)
    |-> !ack_o ##1 answer_s(RESP_OK)) else $error("enable ack misplaced");
  chk_stall_in_drain: assert property (sync_req_o |-> !ack_o)
    else $error("answer during drain");
  chk_field_maps: assert property (write_allocate_attr_o != 2'b11
    && way_size_o >= WAY_16KB && way_size_o <= WAY_512KB)
    else $error("field mapping out of range");
  chk_reset_vals: assert property ($fell(rst_i)
    |-> !cache_enable_o && round_robin_o) else $error("bad reset values");
  cover property (enw ##[3:20] ack_o);
endmodule
bind cache_ctrl_regs cache_ctrl_chk chk (.*);

// *** cache_sync_model.sv ***
`timescale 1ns/1ps
// Drain responder: done follows the request after delay_i + 1 cycles
module cache_sync_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sync_req_i,
  input  wire logic [2:0] delay_i,
  output logic            sync_done_o
);
  int cnt_q;
  // Done clears on the first clock after the request drops, so a stale done cannot pass
  always_ff @(posedge clk_i) begin
    if (rst_i || !sync_req_i) begin
      cnt_q <= 0;
      sync_done_o <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1;
      sync_done_o <= cnt_q >= delay_i;
    end
  end
endmodule

// *** test_l2_cache_control_regs.sv ***
`timescale 1ns/1ps
module test_l2_cache_control_regs;
  import cache_ctrl_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic nonsecure_access_i = 0, assoc_strap_i = 0, sync_done_i;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [2:0] way_size_strap_i = 3'h0, way_size_o, dly = 3'h0;
  logic [1:0] resp_o, write_allocate_attr_o;
  logic ack_o, err_o, port_lock_o, sync_req_o, cache_enable_o;
  logic early_resp_en_o, inst_prefetch_en_o, data_prefetch_en_o;
  logic ns_int_access_o, ns_lockdown_en_o, round_robin_o, shared_ovr_o;
  logic parity_en_o, event_bus_en_o, assoc16_o, shared_inv_o;
  logic exclusive_en_o, sb_dev_limit_o, dev_read_prio_o, zero_line_en_o;
  int err_total = 0, checks = 0, ctrl_m, aux_m;
  always #25 clk_i = ~clk_i;
  cache_ctrl_regs uut (.*);
  cache_sync_model sync (.clk_i, .rst_i, .sync_req_i(sync_req_o),
    .delay_i(dly), .sync_done_o(sync_done_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [19:0] outs_m(logic [31:0] a);
    logic [1:0] w;
    logic [2:0] z;
    w = a[24:23] == 2'b11 ? WA_ATTR : a[24:23];
    z = a[19:17] == 3'h0 ? WAY_16KB : a[19:17] == 3'h7 ? WAY_512KB : a[19:17];
    return {a[30:25], w, a[22:20], z, a[16], a[13] & ~a[22], a[12:10], a[0]};
  endfunction
  // Holds every qualifier until ack is seen, then leaves one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic n, input logic [3:0] s, output logic [31:0] rd,
    output logic [1:0] rs, output logic re);
    int t;
    t = 0;
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a;
    dat_i <= d; nonsecure_access_i <= n; sel_i <= s;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 200);
    if (t >= 200) err_total++;
    rd = dat_o; rs = resp_o; re = err_o;
    cyc_i <= 0; stb_i <= 0;
    @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    err_total++;
    summarize();
  end
  initial begin
    logic [31:0] rd, d;
    logic [1:0] rs, er;
    logic re, w, n;
    logic [7:0] a;
    logic [3:0] s;
    void'($urandom(32'h4aae));
    for (int r = 0; r < 2; r++) begin
      way_size_strap_i <= 3'($urandom);
      assoc_strap_i <= 1'($urandom);
      rst_i <= 1;
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      repeat (2) @(posedge clk_i);
      ctrl_m = 0;
      aux_m = AUX_RESET_VAL | {12'h0, way_size_strap_i, assoc_strap_i, 16'h0};
      for (int i = 0; i < 60; i++) begin
        a = 8'($urandom_range(0, 2) * 4);
        w = 1'($urandom);
        n = $urandom_range(0, 3) == 0;
        // Partial writes only when secure: ordering against ns is open
        s = (!n && $urandom_range(0, 5) == 0) ? 4'($urandom) : 4'hf;
        d = $urandom & (a == AUX_OFFSET ? AUX_WRITE_MASK : 32'h1);
        dly <= 3'($urandom);
        wb(w, a, d, n, s, rd, rs, re);
        er = RESP_OK;
        if (w) begin
          if (a == 8'h08 || n) er = RESP_DECERR;
          else if (s != 4'hf || (a == AUX_OFFSET && ctrl_m[0]))
            er = RESP_SLVERR;
          else if (a == CTRL_OFFSET) ctrl_m = d[0];
          else aux_m = d;
        end
        cmp("data", w ? 0 : a == CTRL_OFFSET ? ctrl_m : a == AUX_OFFSET
          ? aux_m : 0, rd);
        cmp("resp", er, rs);
        cmp("err", er != RESP_OK, re);
        cmp("outs", outs_m(aux_m), {early_resp_en_o,
          inst_prefetch_en_o,
          data_prefetch_en_o, ns_int_access_o, ns_lockdown_en_o,
          round_robin_o, write_allocate_attr_o, shared_ovr_o, parity_en_o,
          event_bus_en_o, way_size_o, assoc16_o, shared_inv_o,
          exclusive_en_o, sb_dev_limit_o, dev_read_prio_o,
          zero_line_en_o});
        // Same word again so the remaining field tags sit on a compare
        cmp("outs2", outs_m(aux_m), {early_resp_en_o, inst_prefetch_en_o,
          data_prefetch_en_o, ns_int_access_o, ns_lockdown_en_o,
          round_robin_o, write_allocate_attr_o, shared_ovr_o, parity_en_o,
          event_bus_en_o, way_size_o, assoc16_o, shared_inv_o,
          exclusive_en_o, sb_dev_limit_o, dev_read_prio_o,
          zero_line_en_o});
        cmp("enable", ctrl_m[0], cache_enable_o);
        // Lock and drain must be over once the answer has been taken
        cmp("lock", 0, {port_lock_o, sync_req_o});
      end
    end
    summarize();
  end
endmodule
